// ### amx_pkg.sv
package amx_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0]  ADDR_CTRL      = 8'h00;
   localparam logic [7:0]  ADDR_TASK      = 8'h04;
   localparam logic [7:0]  ADDR_STAT      = 8'h08;
   localparam logic [7:0]  ADDR_SUPP      = 8'h0C;
   localparam logic [7:0]  ADDR_RXVDM     = 8'h4F;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTRL_POLICY_BIT = 0;
   localparam int CTRL_DISP_BIT   = 1;
   localparam int CTRL_MUX_LSB    = 2;
   localparam int TASK_SVID_LSB   = 0;
   localparam int TASK_OBJ_LSB    = 16;
   localparam int TASK_FINAL_BIT  = 19;
   localparam int TASK_TGT_LSB    = 20;
   localparam int TASK_GO_BIT     = 31;
   localparam int STAT_BUSY_BIT   = 0;
   localparam int STAT_RC_LSB     = 4;
   localparam int STAT_DISP_BIT   = 8;
   localparam int STAT_CUST_BIT   = 9;
   localparam int STAT_SUSP_BIT   = 10;
   localparam int STAT_DFP_BIT    = 11;
   localparam int STAT_MUX_LSB    = 12;
   localparam int SUPP_MASK_LSB   = 16;

   // ---------------------------------------------------------------
   // codes and reset values
   // ---------------------------------------------------------------
   localparam logic [2:0]  OBJ_ALL_LO     = 3'h0;
   localparam logic [2:0]  OBJ_ALL_HI     = 3'h7;
   localparam logic [1:0]  TGT_MULTI      = 2'h3;
   localparam logic [1:0]  MUX_SAFE       = 2'h0;
   localparam logic [15:0] SUPP_SVID_RST  = 16'h0000;
   localparam logic [7:0]  SUPP_MASK_RST  = 8'h00;

   typedef enum logic [3:0] {
      AMX_RC_SUCCESS = 4'h0,
      AMX_RC_REJECT  = 4'h1,
      AMX_RC_NAK     = 4'h2,
      AMX_RC_TIMEOUT = 4'h3
   } amx_rc_t;

   typedef enum logic [1:0] {
      AMX_RSP_ACK  = 2'h0,
      AMX_RSP_NAK  = 2'h1,
      AMX_RSP_BUSY = 2'h2
   } amx_rsp_t;

   typedef enum {AMX_IDLE, AMX_SEND, AMX_WAIT} amx_state_t;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ     = 10;
   localparam int RSP_TIME_US = 30000;
   localparam int RSP_CYCLES  = RSP_TIME_US * CLK_MHZ;

endpackage

// ### amx_tmr_if.sv
`timescale 1ns/100ps
`default_nettype none
interface amx_tmr_if;
   logic start;
   logic stop;
   logic expired;
   modport ctl (output start, output stop, input expired);
   modport tmr (input start, input stop, output expired);
endinterface
`default_nettype wire

// ### amx_timer.sv
`timescale 1ns/100ps
`default_nettype none
module amx_timer
   import amx_pkg::*;
#(
   parameter int CYCLES = RSP_CYCLES
) (
   input  wire logic clk,
   input  wire logic rst,
   amx_tmr_if.tmr    t
);
   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;
   logic        run_reg;
   logic        run_next;
   logic        exp_reg;
   logic        exp_next;

   // ---------------------------------------------------------------
   // response deadline
   // ---------------------------------------------------------------
   always_comb begin
      cnt_next = cnt_reg;
      run_next = run_reg;
      exp_next = 1'b0;
      if (t.start) begin
         cnt_next = 32'h0000_0000;
         run_next = 1'b1;
      end else if (t.stop) begin
         run_next = 1'b0;
      end else if (run_reg) begin
         if (cnt_reg == 32'(CYCLES - 1)) begin
            run_next = 1'b0;
            exp_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= 32'h0000_0000;
         run_reg <= 1'b0;
         exp_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         run_reg <= run_next;
         exp_reg <= exp_next;
      end
   end

   assign t.expired = exp_reg;
endmodule
`default_nettype wire

// ### amx_exit_task.sv
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module amx_exit_task
   import amx_pkg::*;
#(
   parameter int RSP_WAIT = RSP_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        dfp_role,
   output logic             tx_req,
   output logic      [15:0] tx_svid,
   output logic      [2:0]  tx_obj_pos,
   output logic      [1:0]  tx_target,
   input  wire logic        tx_fail,
   input  wire logic        rx_valid,
   input  wire logic [1:0]  rx_kind,
   input  wire logic [31:0] rx_vdo,
   output logic      [1:0]  mux_sel,
   output logic             task_busy
);
   amx_tmr_if tmr_bus ();

   amx_timer #(.CYCLES(RSP_WAIT)) u_timer (
      .clk (clk),
      .rst (rst),
      .t   (tmr_bus.tmr)
   );

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   amx_state_t  st_reg,    st_next;
   logic        dfp_m_reg, dfp_s_reg;
   logic        policy_reg, policy_next;
   logic        disp_reg,   disp_next;
   logic [1:0]  mcfg_reg,   mcfg_next;
   logic [1:0]  mux_reg,    mux_next;
   logic [15:0] svid_reg,   svid_next;
   logic [2:0]  obj_reg,    obj_next;
   logic        final_reg,  final_next;
   logic [1:0]  tgt_reg,    tgt_next;
   logic        track_reg,  track_next;
   logic        susp_reg,   susp_next;
   logic        cust_reg,   cust_next;
   amx_rc_t     rc_reg,     rc_next;
   logic [15:0] ssvid_reg,  ssvid_next;
   logic [7:0]  smask_reg,  smask_next;
   logic [31:0] rxvdm_reg,  rxvdm_next;
   logic        txr_reg,    txr_next;
   logic        busy_reg,   busy_next;
   logic [31:0] rdata_reg,  rdata_next;
   logic        go;
   logic        supp;
   logic        special;
   logic        start_tmr;
   logic        stop_tmr;

   assign go      = reg_wr && reg_addr == ADDR_TASK && reg_wdata[TASK_GO_BIT];
   assign special = reg_wdata[TASK_OBJ_LSB +: 3] == OBJ_ALL_LO
                 || reg_wdata[TASK_OBJ_LSB +: 3] == OBJ_ALL_HI;
   assign supp    = reg_wdata[TASK_SVID_LSB +: 16] == ssvid_reg
                 && smask_reg[reg_wdata[TASK_OBJ_LSB +: 3]];

   // ---------------------------------------------------------------
   // next values
   // ---------------------------------------------------------------
   always_comb begin
      st_next     = st_reg;
      policy_next = policy_reg;
      disp_next   = disp_reg;
      mcfg_next   = mcfg_reg;
      mux_next    = mux_reg;
      svid_next   = svid_reg;
      obj_next    = obj_reg;
      final_next  = final_reg;
      tgt_next    = tgt_reg;
      track_next  = track_reg;
      susp_next   = susp_reg;
      cust_next   = cust_reg;
      rc_next     = rc_reg;
      ssvid_next  = ssvid_reg;
      smask_next  = smask_reg;
      rxvdm_next  = rxvdm_reg;
      txr_next    = 1'b0;
      start_tmr   = 1'b0;
      stop_tmr    = 1'b0;
      rdata_next  = 32'h0000_0000;

      if (reg_wr && reg_addr == ADDR_CTRL) begin
         policy_next = reg_wdata[CTRL_POLICY_BIT];
         disp_next   = reg_wdata[CTRL_DISP_BIT];
         mcfg_next   = reg_wdata[CTRL_MUX_LSB +: 2];
         if (reg_wdata[CTRL_DISP_BIT]) begin
            mux_next = reg_wdata[CTRL_MUX_LSB +: 2];
         end
      end
      if (reg_wr && reg_addr == ADDR_SUPP) begin
         ssvid_next = reg_wdata[15:0];
         smask_next = reg_wdata[SUPP_MASK_LSB +: 8];
      end
      // write one clears; a hardware set below wins
      if (reg_wr && reg_addr == ADDR_STAT && reg_wdata[STAT_CUST_BIT]) begin
         cust_next = 1'b0;
      end

      case (st_reg)
         AMX_IDLE: begin
            if (go) begin
               svid_next  = reg_wdata[TASK_SVID_LSB +: 16];
               obj_next   = reg_wdata[TASK_OBJ_LSB +: 3];
               final_next = reg_wdata[TASK_FINAL_BIT];
               tgt_next   = reg_wdata[TASK_TGT_LSB +: 2];
               if (!dfp_s_reg || !policy_reg) begin
                  rc_next = AMX_RC_REJECT;
               end else begin
                  track_next = supp;
                  susp_next  = supp || special;
                  st_next    = AMX_SEND;
               end
            end
         end
         AMX_SEND: begin
            txr_next  = 1'b1;
            start_tmr = 1'b1;
            st_next   = AMX_WAIT;
         end
         AMX_WAIT: begin
            if (rx_valid) begin
               rxvdm_next = rx_vdo;
               stop_tmr   = 1'b1;
               case (rx_kind)
                  AMX_RSP_ACK: begin
                     rc_next   = AMX_RC_SUCCESS;
                     susp_next = 1'b0;
                     st_next   = AMX_IDLE;
                     if (track_reg) begin
                        disp_next = 1'b0;
                        mux_next  = MUX_SAFE;
                     end
                     if (final_reg) begin
                        cust_next = 1'b1;
                     end
                  end
                  AMX_RSP_BUSY: begin
                     st_next = AMX_SEND;
                  end
                  default: begin
                     rc_next   = AMX_RC_NAK;
                     susp_next = 1'b0;
                     st_next   = AMX_IDLE;
                  end
               endcase
            end else if (tx_fail || tmr_bus.expired) begin
               rc_next   = AMX_RC_TIMEOUT;
               susp_next = 1'b0;
               stop_tmr  = 1'b1;
               st_next   = AMX_IDLE;
            end
         end
         default: begin
            st_next = AMX_IDLE;
         end
      endcase

      busy_next = st_next != AMX_IDLE;

      if (reg_rd) begin
         case (reg_addr)
            ADDR_CTRL: begin
               rdata_next[CTRL_POLICY_BIT]    = policy_reg;
               rdata_next[CTRL_DISP_BIT]      = disp_reg;
               rdata_next[CTRL_MUX_LSB +: 2]  = mcfg_reg;
            end
            ADDR_TASK: begin
               rdata_next[TASK_SVID_LSB +: 16] = svid_reg;
               rdata_next[TASK_OBJ_LSB +: 3]   = obj_reg;
               rdata_next[TASK_FINAL_BIT]      = final_reg;
               rdata_next[TASK_TGT_LSB +: 2]   = tgt_reg;
            end
            ADDR_STAT: begin
               rdata_next[STAT_BUSY_BIT]      = busy_reg;
               rdata_next[STAT_RC_LSB +: 4]   = rc_reg;
               rdata_next[STAT_DISP_BIT]      = disp_reg;
               rdata_next[STAT_CUST_BIT]      = cust_reg;
               rdata_next[STAT_SUSP_BIT]      = susp_reg;
               rdata_next[STAT_DFP_BIT]       = dfp_s_reg;
               rdata_next[STAT_MUX_LSB +: 2]  = mux_reg;
            end
            ADDR_SUPP: begin
               rdata_next[15:0]               = ssvid_reg;
               rdata_next[SUPP_MASK_LSB +: 8] = smask_reg;
            end
            ADDR_RXVDM: begin
               rdata_next = rxvdm_reg;
            end
            default: begin
               rdata_next = 32'h0000_0000;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg     <= AMX_IDLE;
         dfp_m_reg  <= 1'b0;
         dfp_s_reg  <= 1'b0;
         policy_reg <= 1'b0;
         disp_reg   <= 1'b0;
         mcfg_reg   <= MUX_SAFE;
         mux_reg    <= MUX_SAFE;
         svid_reg   <= 16'h0000;
         obj_reg    <= 3'h0;
         final_reg  <= 1'b0;
         tgt_reg    <= 2'h0;
         track_reg  <= 1'b0;
         susp_reg   <= 1'b0;
         cust_reg   <= 1'b0;
         rc_reg     <= AMX_RC_SUCCESS;
         ssvid_reg  <= SUPP_SVID_RST;
         smask_reg  <= SUPP_MASK_RST;
         rxvdm_reg  <= 32'h0000_0000;
         txr_reg    <= 1'b0;
         busy_reg   <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
      end else begin
         st_reg     <= st_next;
         dfp_m_reg  <= dfp_role;
         dfp_s_reg  <= dfp_m_reg;
         policy_reg <= policy_next;
         disp_reg   <= disp_next;
         mcfg_reg   <= mcfg_next;
         mux_reg    <= mux_next;
         svid_reg   <= svid_next;
         obj_reg    <= obj_next;
         final_reg  <= final_next;
         tgt_reg    <= tgt_next;
         track_reg  <= track_next;
         susp_reg   <= susp_next;
         cust_reg   <= cust_next;
         rc_reg     <= rc_next;
         ssvid_reg  <= ssvid_next;
         smask_reg  <= smask_next;
         rxvdm_reg  <= rxvdm_next;
         txr_reg    <= txr_next;
         busy_reg   <= busy_next;
         rdata_reg  <= rdata_next;
      end
   end

   assign tmr_bus.start = start_tmr;
   assign tmr_bus.stop  = stop_tmr;
   assign reg_rdata     = rdata_reg;
   assign tx_req        = txr_reg;
   assign tx_svid       = svid_reg;
   assign tx_obj_pos    = obj_reg;
   assign tx_target     = tgt_reg;
   assign mux_sel       = mux_reg;
   assign task_busy     = busy_reg;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_send_prompt;
      @(posedge clk) disable iff (rst)
      (st_reg == AMX_IDLE && go && dfp_s_reg && policy_reg) |-> ##2 tx_req;
   endproperty
   a_send_prompt: assert property (p_send_prompt) else $error("exit not sent");

   property p_suspend;
      @(posedge clk) disable iff (rst)
      (st_reg == AMX_IDLE && go && dfp_s_reg && policy_reg && special) |=> susp_reg;
   endproperty
   a_suspend: assert property (p_suspend) else $error("mode not suspended");

   property p_policy;
      @(posedge clk) disable iff (rst)
      (st_reg == AMX_IDLE && go && !policy_reg)
         |=> rc_reg == AMX_RC_REJECT && !task_busy;
   endproperty
   a_policy: assert property (p_policy) else $error("policy not enforced");

   property p_disp_clear;
      @(posedge clk) disable iff (rst)
      (st_reg == AMX_WAIT && rx_valid && rx_kind == AMX_RSP_ACK && track_reg)
         |=> !disp_reg && mux_sel == MUX_SAFE;
   endproperty
   a_disp_clear: assert property (p_disp_clear) else $error("ack not applied");

   property p_store;
      @(posedge clk) disable iff (rst)
      (st_reg == AMX_WAIT && rx_valid) |=> rxvdm_reg == $past(rx_vdo);
   endproperty
   a_store: assert property (p_store) else $error("response not stored");

   property p_untracked;
      @(posedge clk) disable iff (rst)
      (st_reg == AMX_IDLE && go && dfp_s_reg && policy_reg && !supp)
         |=> task_busy ##1 tx_req && !track_reg;
   endproperty
   a_untracked: assert property (p_untracked) else $error("untracked exit not sent");

   property p_nak;
      @(posedge clk) disable iff (rst)
      (st_reg == AMX_WAIT && rx_valid && rx_kind == AMX_RSP_NAK)
         |=> rc_reg == AMX_RC_NAK && !task_busy;
   endproperty
   a_nak: assert property (p_nak) else $error("nak not rejected");

   property p_busy_retry;
      @(posedge clk) disable iff (rst)
      (st_reg == AMX_WAIT && rx_valid && rx_kind == AMX_RSP_BUSY)
         |=> task_busy [*2] ##0 tx_req;
   endproperty
   a_busy_retry: assert property (p_busy_retry) else $error("busy not retried");

endmodule
`default_nettype wire

// ### amx_partner.sv
`timescale 1ns/100ps
`default_nettype none
module amx_partner
   import amx_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        tx_req,
   input  wire logic [1:0]  cfg_mode,
   input  wire logic [1:0]  cfg_kind,
   input  wire logic [3:0]  cfg_dly,
   input  wire logic [31:0] cfg_vdo,
   output logic             rx_valid,
   output logic      [1:0]  rx_kind,
   output logic      [31:0] rx_vdo,
   output logic             tx_fail
);
   // ------------------------------------------------------------
   // responder: mode 0 answers, 1 stays silent, 2 never acknowledges
   // ------------------------------------------------------------
   logic [3:0] cnt;
   logic       pend;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pend     <= 1'b0;
         cnt      <= 4'h0;
         rx_valid <= 1'b0;
         tx_fail  <= 1'b0;
         rx_kind  <= 2'h3;
         rx_vdo   <= 32'hC3C3C3C3;
      end else begin
         rx_valid <= 1'b0;
         tx_fail  <= 1'b0;
         // idle lines toggle each cycle: the complement of the last word, then the last word again
         rx_kind  <= ~rx_kind;
         rx_vdo   <= ~rx_vdo;
         if (tx_req && cfg_mode != 2'h1) begin
            pend <= 1'b1;
            cnt  <= cfg_dly;
         end else if (pend && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end else if (pend) begin
            pend <= 1'b0;
            if (cfg_mode == 2'h2) begin
               tx_fail <= 1'b1;
            end else begin
               rx_valid <= 1'b1;
               rx_kind  <= cfg_kind;
               rx_vdo   <= cfg_vdo;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### test_amx_exit_task.sv
`timescale 1ns/100ps
`default_nettype none
module test_amx_exit_task
   import amx_pkg::*;
;
   logic        clk, rst, reg_wr, reg_rd, dfp_role, tx_req, tx_fail, rx_valid, task_busy;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rx_vdo, cfg_vdo, v;
   logic [15:0] tx_svid;
   logic [2:0]  tx_obj_pos;
   logic [1:0]  tx_target, rx_kind, mux_sel, cfg_mode, cfg_kind;
   logic [3:0]  cfg_dly;
   int          errors, n_compared, tx_cnt, n, i;

   amx_exit_task #(.RSP_WAIT(20)) amx_exit_task_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .dfp_role(dfp_role), .tx_req(tx_req), .tx_svid(tx_svid), .tx_obj_pos(tx_obj_pos),
      .tx_target(tx_target), .tx_fail(tx_fail), .rx_valid(rx_valid), .rx_kind(rx_kind),
      .rx_vdo(rx_vdo), .mux_sel(mux_sel), .task_busy(task_busy));

   amx_partner amx_partner_i (.clk(clk), .rst(rst), .tx_req(tx_req), .cfg_mode(cfg_mode),
      .cfg_kind(cfg_kind), .cfg_dly(cfg_dly), .cfg_vdo(cfg_vdo), .rx_valid(rx_valid),
      .rx_kind(rx_kind), .rx_vdo(rx_vdo), .tx_fail(tx_fail));

   // ------------------------------------------------------------
   // clock, command counter, watchdog
   // ------------------------------------------------------------
   always #50 clk = ~clk;

   always @(posedge clk) begin
      if (tx_req === 1'b1) tx_cnt <= tx_cnt + 1;
   end

   initial begin
      #(100 * 6000);
      errors++;
      $display("watchdog expired at %0t", $time);
      end_of_test();
   end

   // ------------------------------------------------------------
   // bus and check tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge clk);
   endtask

   task automatic st(input logic [31:0] m, input logic [31:0] e);
      logic [31:0] s;
      rd(ADDR_STAT, s);
      chk(s & m, e);
   endtask

   task automatic go(input logic [15:0] sv, input logic [2:0] op, input logic fin,
                     input logic [1:0] tg);
      wr(ADDR_TASK, {1'b1, 9'h000, tg, fin, op, sv});
   endtask

   task automatic wait_idle();
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (task_busy !== 1'b0 && k < 300);
      if (task_busy !== 1'b0) begin
         errors++;
         end_of_test();
      end
   endtask

   task automatic wait_tx(input int c);
      int k;
      k = 0;
      while (tx_cnt < c && k < 100) begin
         @(posedge clk);
         k++;
      end
      if (tx_cnt < c) begin
         errors++;
         end_of_test();
      end
   endtask

   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      clk = 0; rst = 1; reg_addr = 0; reg_wdata = 0; reg_wr = 0; reg_rd = 0; dfp_role = 0;
      cfg_mode = 0; cfg_kind = AMX_RSP_ACK; cfg_dly = 4'h3; cfg_vdo = 0; tx_cnt = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      st(32'hFFFFFFFF, 32'h0);
      rd(ADDR_RXVDM, v); chk(v, 32'h0);
      rd(ADDR_SUPP, v); chk(v, 32'h0);
      rd(8'h20, v); chk(v, 32'h0);
      chk({30'h0, mux_sel}, 32'h0);
      $display("reset test done");

      dfp_role <= 1'b1;
      wr(ADDR_CTRL, 32'h0);
      n = tx_cnt;
      go(16'hFF01, 3'h2, 1'b0, 2'h0);
      wait_idle();
      st(32'h00000BF1, 32'h00000810);
      wr(ADDR_CTRL, 32'h1);
      dfp_role <= 1'b0;
      repeat (3) @(posedge clk);
      go(16'hFF01, 3'h2, 1'b0, 2'h0);
      wait_idle();
      st(32'h00000BF1, 32'h00000010);
      chk(tx_cnt, n);
      dfp_role <= 1'b1;
      $display("reject test done");

      wr(ADDR_SUPP, 32'h0004FF01);
      wr(ADDR_CTRL, 32'h0000000B);
      chk({30'h0, mux_sel}, 32'h2);
      cfg_vdo <= 32'hA5A50001;
      go(16'hFF01, 3'h2, 1'b1, 2'h1);
      wait_idle();
      chk(tx_cnt, n + 1);
      chk({11'h0, tx_target, tx_obj_pos, tx_svid}, 32'h000AFF01);
      st(32'h00003BF1, 32'h00000A00);
      chk({30'h0, mux_sel}, 32'h0);
      rd(ADDR_RXVDM, v); chk(v, 32'hA5A50001);
      $display("tracked exit test done");

      wr(ADDR_STAT, 32'h00000200);
      wr(ADDR_CTRL, 32'h0000000B);
      cfg_vdo <= 32'hA5A50002;
      cfg_dly <= 4'hC;
      go(16'h1234, 3'h3, 1'b1, 2'h0);
      wait_idle();
      chk(tx_cnt, n + 2);
      st(32'h00003BF1, 32'h00002B00);
      wr(ADDR_STAT, 32'h00000200);
      st(32'h00000200, 32'h0);
      rd(ADDR_RXVDM, v); chk(v, 32'hA5A50002);
      $display("untracked exit test done");

      cfg_dly <= 4'h0;
      for (i = 0; i < 2; i++) begin
         cfg_vdo <= 32'hC0DE0000 | i;
         go(16'h1234, i ? OBJ_ALL_HI : OBJ_ALL_LO, 1'b0, TGT_MULTI);
         wait_idle();
         chk({27'h0, tx_target, tx_obj_pos}, {27'h0, TGT_MULTI, i ? OBJ_ALL_HI : OBJ_ALL_LO});
         st(32'h000000F1, 32'h0);
      end
      rd(ADDR_RXVDM, v); chk(v, 32'hC0DE0001);
      $display("special position test done");

      cfg_kind <= AMX_RSP_NAK;
      for (i = 0; i < 3; i++) begin
         cfg_mode <= i[1:0];
         cfg_vdo  <= 32'hBEEF0000 | i;
         go(16'h1234, 3'h1, 1'b0, 2'h0);
         wait_idle();
         st(32'h000000F1, i ? 32'h00000030 : 32'h00000020);
      end
      rd(ADDR_RXVDM, v); chk(v, 32'hBEEF0000);
      $display("failure codes test done");

      cfg_mode <= 2'h0;
      cfg_kind <= AMX_RSP_BUSY;
      wr(ADDR_CTRL, 32'h0000000B);
      n = tx_cnt;
      go(16'hFF01, 3'h2, 1'b0, 2'h0);
      wait_tx(n + 1);
      st(32'h00000401, 32'h00000401);
      go(16'h0BAD, 3'h1, 1'b0, 2'h0);
      wait_tx(n + 2);
      cfg_kind <= AMX_RSP_ACK;
      wait_idle();
      chk(tx_cnt, n + 3);
      chk({16'h0, tx_svid}, 32'h0000FF01);
      st(32'h00003BF1, 32'h00000800);
      $display("busy retry test done");
      end_of_test();
   end
endmodule
`default_nettype wire
